// file: rtl/arp_readout.sv
// Conversion busy control and result readout over word, byte and serial pins
// Overview of operation
// - Busy rises only after both start inputs have seen a rising edge.
// - Start input edges are ignored while busy is high.
// - Busy stays high until all eight results are latched for readout.
// - Marker pin is released until chip select falls, then it drives.
// - Word mode: marker high on first read strobe fall, low from the second.
// - Byte mode: marker high for two strobe falls, low from the third.
// - Serial mode: marker high at select fall, low on 16th clock fall.
// - Selector low picks word; high picks serial or byte by top pin.
// - Word mode: top pin drives result MSB while select and strobe low.
// - Byte mode: byte-order pin high sends high byte first, else low first.
// - Word mode: all data pins drive current result bits during a read.
// - Byte mode: bit 8 pin stays released.
// - Byte mode: bit 7 pin carries each output byte's MSB.
// - Serial: first line carries channels 1-4, second channels 5-8.
// - Chip select high releases all data outputs.
// - Serial: select fall enables both lines with previous result MSB.
// - Word mode: strobe falls walk channels upward from channel 1.
`timescale 1ns/10ps
`default_nettype none
module arp_readout (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sample_start_low_group,
	input wire logic sample_start_high_group,
	input wire logic cs_n,
	input wire logic rd_sclk,
	input wire logic interface_selector,
	input wire logic top_bit_or_byte_mode_pin_in,
	input wire logic bit14_or_byte_order_pin_in,
	input wire logic result_valid,
	input wire logic [arp_pkg::CH_W-1:0] result_ch,
	input wire logic [arp_pkg::RES_W-1:0] result_data,
	output logic busy,
	output logic conv_go,
	output logic first_channel_marker,
	output logic first_channel_marker_oe_n,
	output logic [arp_pkg::RES_W-1:0] word_data_bus_out,
	output logic [arp_pkg::RES_W-1:0] word_data_bus_oe_n
);
	import arp_pkg::*;

	logic [SYNC_W-1:0] sync_s;
	logic [3:0] edge_q;
	arp_conv_state_t st_q;
	arp_conv_state_t st_d;
	logic seen_a_q;
	logic seen_b_q;
	logic [NUM_CH-1:0] mask_q;
	logic bank_q;
	logic [BITCNT_W-1:0] rd_cnt_q;
	logic [BITCNT_W-1:0] bit_cnt_q;
	logic [SER_CH_W-1:0] ser_ch_q;
	logic byte_phase_q;
	logic [RES_W-1:0] word_q;
	logic [RES_W-1:0] sh_a_q;
	logic [RES_W-1:0] sh_b_q;
	logic [RES_W-1:0] rdata_a;
	logic [RES_W-1:0] rdata_b;
	logic [RES_W-1:0] pin_d;
	logic [RES_W-1:0] pin_oe_n_d;
	logic [1:0] settle_q;
	logic sel_s;

	// Every pin-side input passes two flops before use
	arp_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk(clk),
		.resetn(resetn),
		.async_in({sample_start_high_group, sample_start_low_group, cs_n, rd_sclk,
			top_bit_or_byte_mode_pin_in, bit14_or_byte_order_pin_in}),
		.sync_out(sync_s)
	);

	// Selector strap gets its own pair of flops
	arp_sync #(
		.W(1)
	) u_sync_sel (
		.clk(clk),
		.resetn(resetn),
		.async_in(interface_selector),
		.sync_out(sel_s)
	);

	// Synchroniser resets to zero, which would read as an active select and strobe
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			settle_q <= 2'h0;
		end else if (!settle_q[1]) begin
			settle_q <= settle_q + 2'h1;
		end
	end

	wire settled = settle_q[1];
	wire sb_s = sync_s[5];
	wire sa_s = sync_s[4];
	wire cs_s = sync_s[3] | ~settled;
	wire rd_s = sync_s[2] | ~settled;
	wire top_s = sync_s[1];
	wire order_s = sync_s[0];

	// Select and strobe start from their idle high level, so no false fall
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			edge_q <= 4'h3;
		end else begin
			edge_q <= {sb_s, sa_s, cs_s, rd_s};
		end
	end

	wire sb_rise = sb_s & ~edge_q[3];
	wire sa_rise = sa_s & ~edge_q[2];
	wire cs_fall = ~cs_s & edge_q[1];
	wire rd_fall = ~rd_s & edge_q[0];

	// Mode decode; in word mode the top pin is our own output and is ignored
	wire mode_word = ~sel_s;
	wire mode_serial = sel_s & ~top_s;
	wire mode_byte = sel_s & top_s;

	// Conversion control
	wire arm_a = seen_a_q | sa_rise;
	wire arm_b = seen_b_q | sb_rise;
	wire all_in = (mask_q == MASK_FULL);

	always_comb begin
		st_d = st_q;
		case (st_q)
			CV_IDLE: begin
				if (arm_a && arm_b) begin
					st_d = CV_BUSY;
				end
			end
			CV_BUSY: begin
				if (all_in) begin
					st_d = CV_LATCH;
				end
			end
			CV_LATCH: begin
				st_d = CV_IDLE;
			end
			default: begin
				st_d = CV_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= CV_IDLE;
			seen_a_q <= 1'b0;
			seen_b_q <= 1'b0;
			mask_q <= MASK_RST;
			bank_q <= 1'b0;
			busy <= 1'b0;
			conv_go <= 1'b0;
		end else begin
			st_q <= st_d;
			conv_go <= (st_q == CV_IDLE) && (st_d == CV_BUSY);
			// Edges only count while idle, so busy masks them
			if (st_q == CV_IDLE && st_d == CV_IDLE) begin
				seen_a_q <= arm_a;
				seen_b_q <= arm_b;
			end else begin
				seen_a_q <= 1'b0;
				seen_b_q <= 1'b0;
			end
			if (st_d == CV_BUSY && st_q == CV_IDLE) begin
				busy <= 1'b1;
				mask_q <= MASK_RST;
			end else if (st_q == CV_BUSY && result_valid) begin
				mask_q[result_ch] <= 1'b1;
			end
			// Bank swap and busy fall share one edge, so old data stays readable until then
			if (st_q == CV_LATCH) begin
				bank_q <= ~bank_q;
				busy <= 1'b0;
			end
		end
	end

	// Fresh results land in the bank that is not being read
	wire wr_en = (st_q == CV_BUSY) && result_valid;
	wire [ADDR_W-1:0] wr_addr = {~bank_q, result_ch};
	wire [CH_W-1:0] par_ch = mode_byte ? rd_cnt_q[3:1] : rd_cnt_q[2:0];
	wire [ADDR_W-1:0] addr_a = mode_serial ? {bank_q, 1'b0, ser_ch_q} : {bank_q, par_ch};
	wire [ADDR_W-1:0] addr_b = {bank_q, 1'b1, ser_ch_q};

	arp_result_mem u_mem (
		.clk(clk),
		.resetn(resetn),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(result_data),
		.rd_addr_a(addr_a),
		.rd_addr_b(addr_b),
		.rd_data_a(rdata_a),
		.rd_data_b(rdata_b)
	);

	// Readout sequencing; read data is prefetched for the next edge
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_cnt_q <= RD_CNT_RST;
			bit_cnt_q <= RD_CNT_RST;
			ser_ch_q <= '0;
			byte_phase_q <= 1'b0;
			word_q <= WORD_RST;
			sh_a_q <= WORD_RST;
			sh_b_q <= WORD_RST;
			first_channel_marker <= 1'b0;
			first_channel_marker_oe_n <= 1'b1;
		end else if (cs_fall) begin
			first_channel_marker_oe_n <= 1'b0;
			first_channel_marker <= mode_serial;
			bit_cnt_q <= RD_CNT_RST;
			if (mode_serial) begin
				sh_a_q <= rdata_a;
				sh_b_q <= rdata_b;
				ser_ch_q <= ser_ch_q + 2'd1;
			end
		end else if (cs_s) begin
			first_channel_marker_oe_n <= 1'b1;
			first_channel_marker <= 1'b0;
			rd_cnt_q <= RD_CNT_RST;
			ser_ch_q <= '0;
		end else if (mode_serial && rd_fall) begin
			bit_cnt_q <= bit_cnt_q + 4'd1;
			if (bit_cnt_q == SER_LAST_BIT) begin
				first_channel_marker <= 1'b0;
				sh_a_q <= rdata_a;
				sh_b_q <= rdata_b;
				ser_ch_q <= ser_ch_q + 2'd1;
			end else begin
				sh_a_q <= {sh_a_q[RES_W-2:0], 1'b0};
				sh_b_q <= {sh_b_q[RES_W-2:0], 1'b0};
			end
		end else if (!mode_serial && rd_fall) begin
			rd_cnt_q <= rd_cnt_q + 4'd1;
			byte_phase_q <= rd_cnt_q[0];
			if (mode_byte) begin
				first_channel_marker <= (rd_cnt_q < 4'd2);
			end else begin
				first_channel_marker <= (rd_cnt_q == RD_CNT_RST);
			end
			if (!mode_byte || !rd_cnt_q[0]) begin
				word_q <= rdata_a;
			end
		end
	end

	// Byte order: high-first when the order pin is high
	wire take_high = order_s ^ byte_phase_q;
	wire [BYTE_W-1:0] byte_out = take_high ? word_q[RES_W-1:BYTE_W] : word_q[BYTE_W-1:0];

	always_comb begin
		pin_d = WORD_RST;
		pin_oe_n_d = PIN_OE_N_RST;
		if (!cs_s) begin
			if (mode_word && !rd_s) begin
				pin_d = word_q;
				pin_oe_n_d = WORD_RST;
			end else if (mode_byte && !rd_s) begin
				// Bit 8 and the upper pins stay released, 15 and 14 are inputs here
				pin_d[BYTE_W-1:0] = byte_out;
				pin_oe_n_d[BYTE_W-1:0] = '0;
			end else if (mode_serial) begin
				pin_d[PIN_SER_A] = sh_a_q[RES_W-1];
				pin_d[PIN_SER_B] = sh_b_q[RES_W-1];
				pin_oe_n_d[PIN_SER_A] = 1'b0;
				pin_oe_n_d[PIN_SER_B] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			word_data_bus_out <= WORD_RST;
			word_data_bus_oe_n <= PIN_OE_N_RST;
		end else begin
			word_data_bus_out <= pin_d;
			word_data_bus_oe_n <= pin_oe_n_d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	AST_BUSY_RISE: assert property ((st_q == CV_IDLE) && arm_a && arm_b |=> busy ##1 conv_go == 1'b0)
		else $error("busy did not rise after both start edges");
	AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(st_q) == CV_IDLE && $past(arm_a) && $past(arm_b))
		else $error("busy rose without both start edges");
	AST_IGNORE_START: assert property (busy |-> !seen_a_q && !seen_b_q)
		else $error("start edge recorded while busy");
	AST_BUSY_HOLD: assert property ($fell(busy) |-> $past(mask_q, 2) == MASK_FULL && $changed(bank_q))
		else $error("busy fell before all results latched");
	AST_MARKER_DRIVE: assert property (cs_fall |=> !first_channel_marker_oe_n)
		else $error("marker not driven after select fall");
	AST_WORD_MARKER: assert property (mode_word && !cs_s && !cs_fall && rd_fall && rd_cnt_q == 4'd1 |=> !first_channel_marker)
		else $error("word marker not low on second strobe");
	AST_BYTE_MARKER: assert property (mode_byte && !cs_s && !cs_fall && rd_fall && rd_cnt_q == 4'd1 |=> first_channel_marker)
		else $error("byte marker dropped on second strobe");
	AST_SER_MARKER: assert property (mode_serial && !cs_s && !cs_fall && rd_fall && bit_cnt_q == SER_LAST_BIT |=> !first_channel_marker)
		else $error("serial marker not low on 16th clock fall");
	AST_RELEASE: assert property (cs_s [*2] |=> (word_data_bus_oe_n == PIN_OE_N_RST) && first_channel_marker_oe_n)
		else $error("outputs driven with select high");
	AST_BYTE_BIT8: assert property (mode_byte |=> word_data_bus_oe_n[PIN_SER_B])
		else $error("bit 8 driven in byte mode");

	COV_CONVERSION: cover property ($fell(busy));
	COV_WORD_READ: cover property (mode_word && rd_fall && !cs_s && rd_cnt_q == 4'd7);
	COV_BYTE_READ: cover property (mode_byte && rd_fall && !cs_s && rd_cnt_q == 4'd3);
	COV_SERIAL_NEXT: cover property (mode_serial && rd_fall && !cs_s && bit_cnt_q == SER_LAST_BIT);
endmodule
`default_nettype wire

// file: rtl/arp_pkg.sv
// Shared constants and types for the converter result readout port
package arp_pkg;
	localparam int NUM_CH = 8;
	localparam int CH_W = 3;
	localparam int RES_W = 16;
	localparam int ADDR_W = 4;
	localparam int BYTE_W = 8;
	localparam int SYNC_W = 6;
	localparam int SER_CH_W = 2;
	localparam int BITCNT_W = 4;
	localparam logic [BITCNT_W-1:0] SER_LAST_BIT = 4'hF;
	localparam logic [BITCNT_W-1:0] RD_CNT_RST = 4'h0;
	localparam logic [RES_W-1:0] WORD_RST = 16'h0000;
	localparam logic [RES_W-1:0] PIN_OE_N_RST = 16'hFFFF;
	localparam logic [NUM_CH-1:0] MASK_RST = 8'h00;
	localparam logic [NUM_CH-1:0] MASK_FULL = 8'hFF;
	// Pin positions on the shared data bus
	localparam int PIN_SER_A = 7;
	localparam int PIN_SER_B = 8;
	// Conversion control states, Gray order along idle, busy, latch
	typedef enum logic [1:0] {
		CV_IDLE = 2'b00,
		CV_BUSY = 2'b01,
		CV_LATCH = 2'b11
	} arp_conv_state_t;
endpackage

// file: rtl/arp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module arp_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// file: rtl/arp_result_mem.sv
// Two-bank result store, one write port, two registered read ports
`timescale 1ns/10ps
`default_nettype none
module arp_result_mem (
	input wire logic clk,
	input wire logic resetn,
	input wire logic wr_en,
	input wire logic [arp_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [arp_pkg::RES_W-1:0] wr_data,
	input wire logic [arp_pkg::ADDR_W-1:0] rd_addr_a,
	input wire logic [arp_pkg::ADDR_W-1:0] rd_addr_b,
	output logic [arp_pkg::RES_W-1:0] rd_data_a,
	output logic [arp_pkg::RES_W-1:0] rd_data_b
);
	import arp_pkg::*;
	logic [RES_W-1:0] mem_q [2*NUM_CH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data_a <= WORD_RST;
			rd_data_b <= WORD_RST;
		end else begin
			rd_data_a <= mem_q[rd_addr_a];
			rd_data_b <= mem_q[rd_addr_b];
		end
	end
endmodule
`default_nettype wire

// file: bench/arp_host.sv
// Host model: chip select, read strobe and serial clock frames
`timescale 1ns/10ps
`default_nettype none
module arp_host (
	input wire logic clk,
	input wire logic mk,
	input wire logic [15:0] q,
	input wire logic [15:0] oe_n,
	output logic cs_n,
	output logic rd_sclk
);
	logic [15:0] w [16];
	logic [15:0] e [16];
	logic [63:0] sa;
	logic [63:0] sb;
	logic [63:0] sm;
	initial begin
		cs_n = 1'b1;
		rd_sclk = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Strobe held low past sync and output flops, edges 4+ clocks apart
	task automatic par(input int n);
		@(posedge clk) cs_n <= 1'b0;
		tick(4);
		for (int k = 0; k < n; k++) begin
			rd_sclk <= 1'b0;
			tick(6);
			@(negedge clk);
			w[k] = q;
			e[k] = oe_n;
			sm[k] = mk;
			@(posedge clk) rd_sclk <= 1'b1;
			tick(4);
		end
		cs_n <= 1'b1;
	endtask
	// Clock idles high between frames; bit taken just before each fall
	task automatic ser();
		@(posedge clk) cs_n <= 1'b0;
		tick(8);
		for (int i = 0; i < 64; i++) begin
			@(negedge clk);
			sa[63-i] = q[7];
			sb[63-i] = q[8];
			sm[i] = mk;
			if (i < 16)
				e[i] = oe_n;
			@(posedge clk) rd_sclk <= 1'b0;
			tick(4);
			rd_sclk <= 1'b1;
			tick(3);
		end
		cs_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// file: bench/arp_readout_test.sv
// Self-checking bench for the result readout port
`timescale 1ns/10ps
`default_nettype none
module arp_readout_test;
	import arp_pkg::*;
	typedef struct packed {
		logic sel;
		logic p15;
		logic p14;
		logic [15:0] pattern;
		logic [15:0] oe;
	} arp_row_t;
	// Word, byte high first, byte low first, serial
	arp_row_t rows [4] = '{
		'{1'b0, 1'b0, 1'b0, 16'hC3A5, 16'h0000},
		'{1'b1, 1'b1, 1'b1, 16'h5A0F, 16'hFF00},
		'{1'b1, 1'b1, 1'b0, 16'h9E61, 16'hFF00},
		'{1'b1, 1'b0, 1'b0, 16'h7B24, 16'hFE7F}
	};
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic st_lo = 1'b0;
	logic st_hi = 1'b0;
	logic sel = 1'b0;
	logic p15_h = 1'b0;
	logic p14_h = 1'b0;
	logic rv = 1'b0;
	logic [2:0] rch = 3'h0;
	logic [15:0] rdat = 16'h0000;
	logic busy;
	logic go;
	logic mk;
	logic mk_oe_n;
	logic [15:0] q;
	logic [15:0] oe_n;
	wire cs_n;
	wire rd_sclk;
	wire p15 = oe_n[15] ? p15_h : q[15];
	wire p14 = oe_n[14] ? p14_h : q[14];
	logic [15:0] res [8];
	int mismatches = 0;
	int compares = 0;
	int gos = 0;
	always #12.5 clk = ~clk;
	always @(posedge clk) if (go === 1'b1) gos <= gos + 1;
	arp_readout DUT (.clk(clk), .resetn(resetn), .sample_start_low_group(st_lo),
		.sample_start_high_group(st_hi), .cs_n(cs_n), .rd_sclk(rd_sclk),
		.interface_selector(sel), .top_bit_or_byte_mode_pin_in(p15),
		.bit14_or_byte_order_pin_in(p14), .result_valid(rv), .result_ch(rch),
		.result_data(rdat), .busy(busy), .conv_go(go), .first_channel_marker(mk),
		.first_channel_marker_oe_n(mk_oe_n), .word_data_bus_out(q), .word_data_bus_oe_n(oe_n));
	arp_host host (.clk(clk), .mk(mk), .q(q), .oe_n(oe_n), .cs_n(cs_n), .rd_sclk(rd_sclk));
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Leaves the valid strobe up so back-to-back calls keep it high with no gap between them
	task automatic put(input int c, input logic [15:0] s);
		res[c] = s ^ (16'h1111 * c[15:0]);
		rv <= 1'b1;
		rch <= c[2:0];
		rdat <= res[c];
		tick(1);
	endtask
	task automatic conv(input logic [15:0] s);
		int n;
		n = gos;
		@(posedge clk) st_lo <= 1'b1;
		tick(6);
		@(negedge clk);
		chk(busy, 1'b0);
		@(posedge clk) st_hi <= 1'b1;
		tick(6);
		@(negedge clk);
		chk(busy, 1'b1);
		@(posedge clk);
		st_lo <= 1'b0;
		st_hi <= 1'b0;
		tick(4);
		st_lo <= 1'b1;
		st_hi <= 1'b1;
		for (int c = 7; c > 0; c--)
			put(c, s);
		rv <= 1'b0;
		tick(4);
		@(negedge clk);
		chk(busy, 1'b1);
		@(posedge clk);
		put(0, s);
		rv <= 1'b0;
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if (busy === 1'b0)
				break;
		end
		chk(busy, 1'b0);
		tick(8);
		@(negedge clk);
		chk(busy, 1'b0);
		chk(gos - n, 1);
		@(posedge clk);
		st_lo <= 1'b0;
		st_hi <= 1'b0;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk({busy, go, mk_oe_n, oe_n}, {3'b001, 16'hFFFF});
		@(posedge clk) resetn <= 1'b1;
		repeat (2) begin
			@(negedge clk);
			chk({mk_oe_n, oe_n}, {1'b1, 16'hFFFF});
		end
		for (int r = 0; r < 4; r++) begin
			@(posedge clk);
			sel <= rows[r].sel;
			p15_h <= rows[r].p15;
			p14_h <= rows[r].p14;
			conv(rows[r].pattern);
			// Reads start only once busy is low
			if (!rows[r].sel) begin
				host.par(9);
				for (int k = 0; k < 9; k++) begin
					chk(host.w[k], res[k % 8]);
					chk(host.e[k], rows[r].oe);
					chk(host.sm[k], k == 0);
				end
			end else if (rows[r].p15) begin
				host.par(16);
				for (int k = 0; k < 16; k++) begin
					if ((k % 2 == 0) == rows[r].p14)
						chk(host.w[k][7:0], res[k/2][15:8]);
					else
						chk(host.w[k][7:0], res[k/2][7:0]);
					chk(host.e[k], rows[r].oe);
					chk(host.sm[k], k < 2);
				end
			end else begin
				host.ser();
				chk(host.sa, {res[0], res[1], res[2], res[3]});
				chk(host.sb, {res[4], res[5], res[6], res[7]});
				chk(host.sm, 64'h0000_0000_0000_FFFF);
				for (int k = 0; k < 16; k++)
					chk(host.e[k], rows[r].oe);
			end
			tick(6);
			@(negedge clk);
			chk({mk_oe_n, oe_n}, {1'b1, 16'hFFFF});
		end
		// Reset during a conversion: busy drops, pins stay released, next set reads cleanly
		@(posedge clk);
		sel <= 1'b0;
		st_lo <= 1'b1;
		st_hi <= 1'b1;
		tick(6);
		@(negedge clk);
		chk(busy, 1'b1);
		@(posedge clk);
		resetn <= 1'b0;
		st_lo <= 1'b0;
		st_hi <= 1'b0;
		@(negedge clk);
		chk({busy, mk_oe_n, oe_n}, {2'b01, 16'hFFFF});
		tick(2);
		resetn <= 1'b1;
		repeat (2) begin
			@(negedge clk);
			chk({busy, mk_oe_n, oe_n}, {2'b01, 16'hFFFF});
		end
		conv(rows[0].pattern);
		host.par(1);
		chk(host.w[0], res[0]);
		chk(host.e[0], 16'h0000);
		chk(host.sm[0], 1'b1);
		end_of_test();
	end
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
